// ### sim/mcw_host_model.sv
module mcw_host_model (
  // Clock
  input wire logic clk,
  // Host I/O write
  output mcw_pkg::mcw_word_t io_addr,
  output logic io_wr,
  output mcw_pkg::mcw_word_t io_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  import mcw_pkg::*;

  initial begin
    io_wr = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 16'h0000;
  end

  ////////////////////////////////////////////////////////////
  // One word per strobe in put; put2 holds the strobe for two words
  task put(input mcw_word_t a, input mcw_word_t d);
    @(posedge clk);
    #1;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge clk);
    #1;
    io_wr = 1'b0;
    // Released bus shows junk
    io_addr = ~a;
    io_wdata = ~d;
  endtask : put

  task put2(input mcw_word_t a0, input mcw_word_t d0,
            input mcw_word_t a1, input mcw_word_t d1);
    @(posedge clk);
    #1;
    io_addr = a0;
    io_wdata = d0;
    io_wr = 1'b1;
    @(posedge clk);
    #1;
    io_addr = a1;
    io_wdata = d1;
    @(posedge clk);
    #1;
    io_wr = 1'b0;
    io_addr = ~a1;
    io_wdata = ~d1;
  endtask : put2
endmodule : mcw_host_model

// ### sim/mcw_write_decode_tb_top.sv
module mcw_write_decode_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import mcw_pkg::*;

  mcw_word_t card_base = 16'h0300;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  mcw_word_t a, d, cmd, gol, itp, dl, dh, pg, oc;
  logic wr, cw, ic;
  logic [31:0] dop;
  logic [3:0] irq;
  mcw_axis_words_t m1, m2, m3;
  mcw_axis_nibbles_t gu;
  mcw_pattern_t pp, pm;
  int n_fail = 0;
  int checks_done = 0;
  logic [3:0] iv [7] = '{4'h4, 4'h5, 4'h7, 4'ha, 4'hb, 4'hc, 4'hf};

  always #12.5 clk = ~clk;

  mcw_host_model host_u (.clk(clk), .io_addr(a), .io_wr(wr),
    .io_wdata(d));

  mcw_write_decode dut_u (.clk(clk), .rst_n(rst_n), .base_addr(card_base),
    .io_addr(a), .io_wr(wr), .io_wdata(d), .command_reg(cmd),
    .command_write(cw), .first_axis_mode_one(m1),
    .first_axis_mode_two(m2), .first_axis_mode_three(m3),
    .general_outputs_upper(gu), .general_output_low_reg(gol),
    .interpolation_mode_reg(itp), .data_low_reg(dl),
    .data_high_reg(dh), .data_operand(dop), .pattern_plus(pp),
    .pattern_minus(pm), .interrupt_clear_reg(ic),
    .pulse_generator_mode_reg(pg), .irq_line_select_reg(irq),
    .output_channel_select_reg(oc));

  ////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [63:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task close_out;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  task w(input mcw_word_t o, v);
    host_u.put(card_base + o, v);
  endtask : w

  initial begin
    #20000;
    n_fail++;
    close_out;
  end

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk("cmd_rst", cmd, 0);
    chk("irq_rst", irq, 0);
    w(16'h0, 16'h0301);
    chk("cmd", cmd, 64'h0301);
    chk("cw_hi", cw, 1);
    w(16'h2, 16'h1234);
    chk("cw_lo", cw, 0);
    chk("m1", m1, 64'h0000_0000_1234_1234);
    w(16'h4, 16'h00a5);
    chk("m2", m2, 64'h0000_0000_00a5_00a5);
    w(16'h6, 16'h0780);
    chk("m3", m3, 64'h0000_0000_0780_0780);
    chk("gu", gu, 64'h0077);
    w(16'h8, 16'h0011);
    chk("gol", gol, 64'h0011);
    w(16'ha, 16'h0022);
    chk("itp", itp, 64'h0022);
    w(16'hc, 16'hbeef);
    w(16'he, 16'hdead);
    chk("dl", dl, 64'hbeef);
    chk("dh", dh, 64'hdead);
    chk("dop", dop, 64'hdeadbeef);
    chk("pp", pp, 64'hbeef_0011_00a5);
    chk("pm", pm, 64'hdead_0022_0780);
    host_u.put2(card_base + 16'hc, 16'h1111, card_base + 16'he, 16'h2222);
    chk("dop_b2b", dop, 64'h2222_1111);
    chk("pp_b2b", pp, 64'h1111_0011_00a5);
    w(16'hc, 16'h3333);
    chk("dop_low", dop, 64'h2222_3333);
    w(16'h0, 16'h0c00);
    w(16'h2, 16'h5678);
    chk("m1_zu", m1, 64'h5678_5678_1234_1234);
    w(16'h12, 16'hffff);
    chk("ic_12", ic, 0);
    w(16'h10, 16'h0000);
    chk("ic_hi", ic, 1);
    w(16'h14, 16'h0003);
    chk("ic_lo", ic, 0);
    chk("pg", pg, 64'h0003);
    w(16'h18, 16'h00c3);
    chk("oc", oc, 64'h00c3);
    for (int i = 0; i < 7; i++) begin
      w(16'h16, {12'h000, iv[i]});
      chk("irq", irq, iv[i]);
    end
    w(16'h16, 16'h0006);
    w(16'h16, 16'h0014);
    chk("irq_bad", irq, 64'hf);
    host_u.put(card_base - 16'h2, 16'hffff);
    host_u.put(card_base + 16'h20, 16'hffff);
    w(16'h1, 16'hffff);
    chk("cmd_out", cmd, 64'h0c00);
    chk("m1_odd", m1, 64'h5678_5678_1234_1234);
    card_base = 16'h0280;
    w(16'h0, 16'h0200);
    chk("cmd_base", cmd, 64'h0200);
    host_u.put(16'h0300, 16'h0f00);
    chk("cmd_old", cmd, 64'h0200);
    close_out;
  end
endmodule : mcw_write_decode_tb_top

// ### verilog/mcw_map.svh
// Behaviour
// - Decode 20 (hex) bytes above configurable base
// - Registers selected by even byte offset
// - Offset 0 loads command register
// - Offset 2 loads axis mode one
// - Offset 4 loads axis mode two
// - Offset 6 loads axis mode three
// - Offset 8 loads general outputs low
// - Offset A loads interpolation mode
// - Offsets C and E build 32-bit data
// - Offsets 4 to E load pattern data
// - Offset 10 clears pending interrupt
// - Offset 14 loads pulse generator mode
// - Offset 16 selects supported IRQ line
// - Offset 18 loads output channel select
`ifndef MCW_MAP_SVH
`define MCW_MAP_SVH

`define MCW_SPAN 16'h0020
`define MCW_OFS_COMMAND 5'h00
`define MCW_OFS_MODE_ONE 5'h02
`define MCW_OFS_MODE_TWO 5'h04
`define MCW_OFS_MODE_THREE 5'h06
`define MCW_OFS_OUT_LOW 5'h08
`define MCW_OFS_INTERP 5'h0a
`define MCW_OFS_DATA_LOW 5'h0c
`define MCW_OFS_DATA_HIGH 5'h0e
`define MCW_OFS_INT_CLEAR 5'h10
`define MCW_OFS_UNUSED 5'h12
`define MCW_OFS_PULSE_MODE 5'h14
`define MCW_OFS_IRQ_SEL 5'h16
`define MCW_OFS_CHAN_SEL 5'h18
`define MCW_RESET_WORD 16'h0000
`define MCW_AXIS_SEL_LSB 8
`define MCW_OUT_UPPER_LSB 8
`define MCW_IRQ_VALID_MASK 16'h9cb0

`endif

// ### verilog/mcw_pkg.sv
package mcw_pkg;
  typedef logic [15:0] mcw_word_t;
  typedef logic [4:0] mcw_offset_t;
  typedef logic [3:0][15:0] mcw_axis_words_t;
  typedef logic [2:0][15:0] mcw_pattern_t;
  typedef logic [3:0][3:0] mcw_axis_nibbles_t;
endpackage : mcw_pkg

// ### verilog/mcw_write_decode.sv
`include "mcw_map.svh"

module mcw_write_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Card base address setting
  input wire mcw_pkg::mcw_word_t base_addr,
  // Host I/O write
  input wire mcw_pkg::mcw_word_t io_addr,
  input wire logic io_wr,
  input wire mcw_pkg::mcw_word_t io_wdata,
  // Register contents
  output mcw_pkg::mcw_word_t command_reg,
  output logic command_write,
  output mcw_pkg::mcw_axis_words_t first_axis_mode_one,
  output mcw_pkg::mcw_axis_words_t first_axis_mode_two,
  output mcw_pkg::mcw_axis_words_t first_axis_mode_three,
  output mcw_pkg::mcw_axis_nibbles_t general_outputs_upper,
  output mcw_pkg::mcw_word_t general_output_low_reg,
  output mcw_pkg::mcw_word_t interpolation_mode_reg,
  output mcw_pkg::mcw_word_t data_low_reg,
  output mcw_pkg::mcw_word_t data_high_reg,
  output logic [31:0] data_operand,
  output mcw_pkg::mcw_pattern_t pattern_plus,
  output mcw_pkg::mcw_pattern_t pattern_minus,
  output logic interrupt_clear_reg,
  output mcw_pkg::mcw_word_t pulse_generator_mode_reg,
  output logic [3:0] irq_line_select_reg,
  output mcw_pkg::mcw_word_t output_channel_select_reg
);
  import mcw_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic in_window(input mcw_word_t addr,
                                     input mcw_word_t base);
    mcw_word_t rel;
    rel = addr - base;
    return (addr >= base) && (rel < `MCW_SPAN);
  endfunction : in_window

  function automatic mcw_offset_t rel_offset(input mcw_word_t addr,
                                             input mcw_word_t base);
    mcw_word_t rel;
    rel = addr - base;
    return rel[4:0];
  endfunction : rel_offset

  logic hit;
  mcw_offset_t ofs;
  logic [3:0] axis_sel;

  assign hit = io_wr && in_window(io_addr, base_addr);
  assign ofs = rel_offset(io_addr, base_addr);
  assign axis_sel = command_reg[`MCW_AXIS_SEL_LSB +: 4];

  function automatic logic wr_at(input logic h, input mcw_offset_t o,
                                 input mcw_offset_t target);
    return h && (o == target);
  endfunction : wr_at

  function automatic logic irq_ok(input logic [3:0] ch);
    mcw_word_t mask;
    mask = `MCW_IRQ_VALID_MASK;
    return mask[ch];
  endfunction : irq_ok

  ////////////////////////////////////////////////////////////////////////
  // Command register

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      command_reg <= `MCW_RESET_WORD;
      command_write <= 1'b0;
    end else begin
      command_write <= wr_at(hit, ofs, `MCW_OFS_COMMAND);
      if (wr_at(hit, ofs, `MCW_OFS_COMMAND)) begin
        command_reg <= io_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-axis mode registers

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      first_axis_mode_one <= '0;
      first_axis_mode_two <= '0;
      first_axis_mode_three <= '0;
    end else begin
      for (int a = 0; a < 4; a++) begin
        if (axis_sel[a]) begin
          if (wr_at(hit, ofs, `MCW_OFS_MODE_ONE)) begin
            first_axis_mode_one[a] <= io_wdata;
          end
          if (wr_at(hit, ofs, `MCW_OFS_MODE_TWO)) begin
            first_axis_mode_two[a] <= io_wdata;
          end
          if (wr_at(hit, ofs, `MCW_OFS_MODE_THREE)) begin
            first_axis_mode_three[a] <= io_wdata;
          end
        end
      end
    end
  end

  always_comb begin
    for (int a = 0; a < 4; a++) begin
      general_outputs_upper[a] =
        first_axis_mode_three[a][`MCW_OUT_UPPER_LSB +: 4];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output and interpolation registers

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      general_output_low_reg <= `MCW_RESET_WORD;
      interpolation_mode_reg <= `MCW_RESET_WORD;
    end else begin
      if (wr_at(hit, ofs, `MCW_OFS_OUT_LOW)) begin
        general_output_low_reg <= io_wdata;
      end
      if (wr_at(hit, ofs, `MCW_OFS_INTERP)) begin
        interpolation_mode_reg <= io_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // 32-bit data operand

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_low_reg <= `MCW_RESET_WORD;
      data_high_reg <= `MCW_RESET_WORD;
    end else begin
      if (wr_at(hit, ofs, `MCW_OFS_DATA_LOW)) begin
        data_low_reg <= io_wdata;
      end
      if (wr_at(hit, ofs, `MCW_OFS_DATA_HIGH)) begin
        data_high_reg <= io_wdata;
      end
    end
  end

  assign data_operand = {data_high_reg, data_low_reg};

  ////////////////////////////////////////////////////////////////////////
  // Bit-pattern interpolation data

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pattern_plus <= '0;
      pattern_minus <= '0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (wr_at(hit, ofs,
                  mcw_offset_t'(`MCW_OFS_MODE_TWO + 4 * p))) begin
          pattern_plus[p] <= io_wdata;
        end
        if (wr_at(hit, ofs,
                  mcw_offset_t'(`MCW_OFS_MODE_THREE + 4 * p))) begin
          pattern_minus[p] <= io_wdata;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt clear, pulse generator, IRQ and channel select

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      interrupt_clear_reg <= 1'b0;
    end else begin
      interrupt_clear_reg <= wr_at(hit, ofs, `MCW_OFS_INT_CLEAR);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse_generator_mode_reg <= `MCW_RESET_WORD;
      irq_line_select_reg <= 4'h0;
      output_channel_select_reg <= `MCW_RESET_WORD;
    end else begin
      if (wr_at(hit, ofs, `MCW_OFS_PULSE_MODE)) begin
        pulse_generator_mode_reg <= io_wdata;
      end
      if (wr_at(hit, ofs, `MCW_OFS_IRQ_SEL) &&
          (io_wdata[15:4] == 12'h000) &&
          irq_ok(io_wdata[3:0])) begin
        irq_line_select_reg <= io_wdata[3:0];
      end
      if (wr_at(hit, ofs, `MCW_OFS_CHAN_SEL)) begin
        output_channel_select_reg <= io_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_window_miss;
    io_wr && !in_window(io_addr, base_addr) |=>
      !command_write && !interrupt_clear_reg && $stable(command_reg);
  endproperty
  a_window_miss: assert property (p_window_miss)
    else $error("Write outside window had an effect");

  property p_command_load;
    wr_at(hit, ofs, `MCW_OFS_COMMAND) |=>
      command_write && command_reg == $past(io_wdata);
  endproperty
  a_command_load: assert property (p_command_load)
    else $error("Command register not loaded");

  property p_mode_one;
    wr_at(hit, ofs, `MCW_OFS_MODE_ONE) && axis_sel[0] |=>
      first_axis_mode_one[0] == $past(io_wdata);
  endproperty
  a_mode_one: assert property (p_mode_one)
    else $error("Axis mode one not loaded");

  property p_unselected_axis;
    hit && !axis_sel[3] |=> $stable(first_axis_mode_two[3]) &&
      $stable(first_axis_mode_three[3]) && $stable(first_axis_mode_one[3]);
  endproperty
  a_unselected_axis: assert property (p_unselected_axis)
    else $error("Unselected axis mode changed");

  property p_out_low;
    wr_at(hit, ofs, `MCW_OFS_OUT_LOW) |=>
      general_output_low_reg == $past(io_wdata);
  endproperty
  a_out_low: assert property (p_out_low)
    else $error("Output register not loaded");

  property p_data_pair;
    wr_at(hit, ofs, `MCW_OFS_DATA_LOW) ##1
      wr_at(hit, ofs, `MCW_OFS_DATA_HIGH) |=>
      data_operand == {$past(io_wdata), $past(io_wdata, 2)};
  endproperty
  a_data_pair: assert property (p_data_pair)
    else $error("Data operand halves wrong");

  property p_pattern;
    wr_at(hit, ofs, `MCW_OFS_DATA_HIGH) |=>
      pattern_minus[2] == $past(io_wdata);
  endproperty
  a_pattern: assert property (p_pattern)
    else $error("Third minus pattern not loaded");

  property p_int_clear;
    interrupt_clear_reg |-> $past(wr_at(hit, ofs, `MCW_OFS_INT_CLEAR));
  endproperty
  a_int_clear: assert property (p_int_clear)
    else $error("Spurious interrupt clear pulse");

  property p_irq_valid;
    irq_ok(irq_line_select_reg) ||
      irq_line_select_reg == 4'h0;
  endproperty
  a_irq_valid: assert property (p_irq_valid)
    else $error("Unsupported IRQ line selected");

  property p_chan_sel;
    wr_at(hit, ofs, `MCW_OFS_CHAN_SEL) |=>
      output_channel_select_reg == $past(io_wdata);
  endproperty
  a_chan_sel: assert property (p_chan_sel)
    else $error("Output channel select not loaded");

  property p_interp;
    wr_at(hit, ofs, `MCW_OFS_INTERP) |=>
      interpolation_mode_reg == $past(io_wdata);
  endproperty
  a_interp: assert property (p_interp)
    else $error("Interpolation mode not loaded");

  property p_pulse_mode;
    wr_at(hit, ofs, `MCW_OFS_PULSE_MODE) |=>
      pulse_generator_mode_reg == $past(io_wdata);
  endproperty
  a_pulse_mode: assert property (p_pulse_mode)
    else $error("Pulse generator mode not loaded");

  c_command: cover property (wr_at(hit, ofs, `MCW_OFS_COMMAND));
  c_data_pair: cover property (wr_at(hit, ofs, `MCW_OFS_DATA_LOW) ##1
    wr_at(hit, ofs, `MCW_OFS_DATA_HIGH));
  c_int_clear: cover property (interrupt_clear_reg);
  c_gap_write: cover property (wr_at(hit, ofs, `MCW_OFS_UNUSED));
  c_irq_select: cover property (wr_at(hit, ofs, `MCW_OFS_IRQ_SEL) &&
    irq_ok(io_wdata[3:0]));
endmodule : mcw_write_decode
